/* common/i2c_addr_ack_defs.vh */
// Constants for the address-phase acknowledge handler.
// Included by core files; holds definitions only.
`ifndef I2C_ADDR_ACK_DEFS_VH
`define I2C_ADDR_ACK_DEFS_VH

`define ADDR_MSB     3'h7
`define BIT_LAST     3'h0
`define HALF_CYCLES  16'h0040
`define ACK_LEVEL    1'b0
`define DIR_WRITE    1'b0

`endif

/* core/i2c_sync2.v */
// Two-stage synchroniser for asynchronous inputs.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps
module i2c_sync2 (
  input  wire i_core_clk, // Core clock
  input  wire i_resetn,   // Async reset, active low
  input  wire i_ce,       // Clock enable
  input  wire i_d,        // Asynchronous level
  output reg  o_q         // Synchronised level
);
  reg meta_reg;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 1'b1;
      o_q      <= 1'b1;
    end else if (i_ce) begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule // i2c_sync2

/* core/i2c_master_address_ack_handler.v */
// Master address byte and acknowledge handling with wait decision.
// Assumes control bits from registers on the core clock; bus pins asynchronous.
`timescale 1ns/1ps
`include "i2c_addr_ack_defs.vh"

module i2c_master_address_ack_handler #(
  parameter HALF_PERIOD = `HALF_CYCLES // Core cycles per SCL half period
) (
  input  wire       i_core_clk,          // Core clock, 250 MHz
  input  wire       i_resetn,            // Async reset, active low
  input  wire       i_ce,                // Clock enable, freezes state when low
  input  wire       i_enable,            // Interface enable
  input  wire       i_master_select,     // Master select bit
  input  wire       i_repeated_start_request, // Restart request pulse
  input  wire       i_dma_mode,          // DMA mode
  input  wire       i_tx_fifo_en,        // Transmit FIFO enable
  input  wire       i_rx_fifo_en,        // Receive FIFO enable
  input  wire       i_rx_fifo_has_data,  // Receive FIFO not empty
  input  wire       i_reserved_addr,     // Reserved-address flag
  input  wire       i_wait_point_select, // Wait point select, unused here
  input  wire       i_tx_holding_empty,  // Transmit holding register empty
  input  wire [7:0] i_transmit_data_reg, // Address byte to send
  input  wire       i_event_clear_wr,    // Write of zero to byte event flag
  input  wire       i_tx_data_wr,        // Write to transmit data register
  input  wire       i_scl_in,            // SCL pin level
  input  wire       i_sda_in,            // SDA pin level
  output reg        o_scl_out,           // SCL output level (always 0)
  output reg        o_scl_oe_n,          // SCL enable, low drives
  output reg        o_sda_out,           // SDA output level (always 0)
  output reg        o_sda_oe_n,          // SDA enable, low drives
  output reg        o_byte_event_flag,   // Byte event flag
  output reg        o_tx_bus_idle_flag,  // Transmit bus idle flag
  output reg        o_received_ack_bit,  // Acknowledge seen (0 = ACK)
  output reg        o_master_active_flag,// Master active flag
  output reg        o_bus_busy_flag,     // Bus busy flag
  output reg        o_data_phase         // Address done, data phase running
);
  // Controller states
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_START    = 3'h1;
  localparam [2:0] ST_BIT_LOW  = 3'h2;
  localparam [2:0] ST_BIT_HIGH = 3'h3;
  localparam [2:0] ST_ACK_LOW  = 3'h4;
  localparam [2:0] ST_ACK_HIGH = 3'h5;
  localparam [2:0] ST_WAIT     = 3'h6;
  localparam [2:0] ST_DATA     = 3'h7;

  wire scl_s;
  wire sda_s;
  reg  [2:0]  state_reg;
  reg  [2:0]  bit_reg;
  reg  [7:0]  shift_reg;
  reg  [15:0] cnt_reg;
  reg         sda_prev_reg;
  reg         scl_prev_reg;
  reg         dir_reg;
  reg         ack_wait_reg;

  // Parameter arithmetic is 32 bits wide; the counter is 16
  wire [31:0] half_full = HALF_PERIOD - 1;
  wire [15:0] half_load = half_full[15:0];
  wire        tick      = (cnt_reg == 16'h0000);
  // One cycle into a low half; needs HALF_PERIOD of 2 or more
  wire        first_low = (cnt_reg == half_load);
  wire start_seen = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire stop_seen  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  wire fifo_on    = i_tx_fifo_en || i_rx_fifo_en;
  wire release_ev = i_event_clear_wr;
  wire abort      = !i_master_select || i_repeated_start_request;

  wire [1:0] pin_in = {i_sda_in, i_scl_in};
  wire [1:0] pin_s;
  genvar     g;

  // Both bus pins pass two flip-flops
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      i2c_sync2 u_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ce       (i_ce),
        .i_d        (pin_in[g]),
        .o_q        (pin_s[g])
      );
    end
  endgenerate

  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg            <= ST_IDLE;
      bit_reg              <= `ADDR_MSB;
      shift_reg            <= 8'h00;
      cnt_reg              <= 16'h0000;
      sda_prev_reg         <= 1'b1;
      scl_prev_reg         <= 1'b1;
      dir_reg              <= `DIR_WRITE;
      ack_wait_reg         <= 1'b0;
      o_scl_out            <= 1'b0;
      o_scl_oe_n           <= 1'b1;
      o_sda_out            <= 1'b0;
      o_sda_oe_n           <= 1'b1;
      o_byte_event_flag    <= 1'b0;
      o_tx_bus_idle_flag   <= 1'b0;
      o_received_ack_bit   <= 1'b1;
      o_master_active_flag <= 1'b0;
      o_bus_busy_flag      <= 1'b0;
      o_data_phase         <= 1'b0;
    end else if (i_ce) begin
      sda_prev_reg <= sda_s;
      scl_prev_reg <= scl_s;
      cnt_reg      <= tick ? half_load : cnt_reg - 16'h0001;
      if (start_seen)
        o_bus_busy_flag <= 1'b1;
      else if (stop_seen)
        o_bus_busy_flag <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          o_scl_oe_n   <= 1'b1;
          o_sda_oe_n   <= 1'b1;
          o_data_phase <= 1'b0;
          if (i_master_select && i_enable && !o_bus_busy_flag && scl_s && sda_s) begin
            shift_reg            <= i_transmit_data_reg;
            dir_reg              <= i_transmit_data_reg[0];
            o_sda_oe_n           <= 1'b0;
            o_master_active_flag <= 1'b1;
            cnt_reg              <= half_load;
            state_reg            <= ST_START;
          end
        end
        ST_START: if (tick) begin
          o_scl_oe_n <= 1'b0;
          bit_reg    <= `ADDR_MSB;
          state_reg  <= ST_BIT_LOW;
        end
        // SDA moves one cycle after SCL falls, never at an SCL edge
        ST_BIT_LOW: begin
          if (first_low)
            o_sda_oe_n <= shift_reg[7];
          if (tick) begin
            o_scl_oe_n <= 1'b1;
            state_reg  <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH: if (tick) begin
          o_scl_oe_n <= 1'b0;
          shift_reg  <= {shift_reg[6:0], 1'b0};
          if (bit_reg != `BIT_LAST) begin
            bit_reg   <= bit_reg - 3'h1;
            state_reg <= ST_BIT_LOW;
          end else if (i_reserved_addr) begin
            o_byte_event_flag <= 1'b1;
            ack_wait_reg      <= 1'b1;
            state_reg         <= ST_WAIT;
          end else begin
            state_reg <= ST_ACK_LOW;
          end
        end
        ST_ACK_LOW: begin
          if (first_low)
            o_sda_oe_n <= 1'b1;
          if (tick) begin
            o_scl_oe_n <= 1'b1;
            state_reg  <= ST_ACK_HIGH;
          end
        end
        ST_ACK_HIGH: if (tick) begin
          o_scl_oe_n         <= 1'b0;
          o_received_ack_bit <= sda_s;
          ack_wait_reg       <= 1'b0;
          if (sda_s != `ACK_LEVEL) begin
            o_byte_event_flag <= 1'b1;
            state_reg         <= ST_WAIT;
          end else if (i_rx_fifo_en && i_rx_fifo_has_data && dir_reg == `DIR_WRITE) begin
            o_byte_event_flag <= 1'b1;
            state_reg         <= ST_WAIT;
          end else if (fifo_on || !i_tx_holding_empty) begin
            state_reg <= ST_DATA;
          end else if (i_dma_mode) begin
            o_tx_bus_idle_flag <= 1'b1;
            state_reg          <= ST_WAIT;
          end else begin
            o_byte_event_flag <= 1'b1;
            state_reg         <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          o_scl_oe_n <= 1'b0;
          cnt_reg    <= half_load;
          if (abort && o_byte_event_flag) begin
            // Free SDA while SCL is still low
            o_sda_oe_n           <= 1'b1;
            o_byte_event_flag    <= 1'b0;
            o_master_active_flag <= i_master_select;
            state_reg            <= ST_IDLE;
          end else if (o_byte_event_flag && release_ev) begin
            o_byte_event_flag <= 1'b0;
            state_reg         <= ack_wait_reg ? ST_ACK_LOW : ST_DATA;
          end else if (o_tx_bus_idle_flag && i_tx_data_wr) begin
            o_tx_bus_idle_flag <= 1'b0;
            state_reg          <= ST_DATA;
          end
        end
        ST_DATA: begin
          o_data_phase <= 1'b1;
          o_scl_oe_n   <= 1'b1;
          if (!i_master_select) begin
            o_master_active_flag <= 1'b0;
            state_reg            <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // i2c_master_address_ack_handler

/* bench/i2c_slave_model.sv */
// Behavioural addressed slave: acks or nacks the address byte.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire       scl,      // Bus clock level
  input  wire       sda,      // Bus data level
  input  wire       nack,     // Refuse the address
  output reg        sda_low,  // Pull data low
  output reg  [7:0] addr_seen // Address byte captured
);
  integer n = 0;
  initial sda_low = 1'b0;
  always @(negedge sda) if (scl) n = 0;
  always @(posedge scl) begin
    if (n < 8) addr_seen = {addr_seen[6:0], sda};
    n = n + 1;
  end
  always @(negedge scl) sda_low <= (n == 8) && !nack;
endmodule // i2c_slave_model

/* bench/i2c_master_address_ack_handler_asserts.sv */
// Checker for the address and acknowledge handler ports.
// Assumes one core clock domain; attached by bind.
`timescale 1ns/1ps
module i2c_addr_ack_chk (
  input wire i_core_clk, // Clock
  input wire i_resetn, // Reset
  input wire i_master_select, // Select
  input wire i_repeated_start_request, // Restart
  input wire i_dma_mode, // DMA
  input wire i_event_clear_wr, // Clear
  input wire i_tx_data_wr, // Data write
  input wire o_scl_oe_n, // SCL enable
  input wire o_sda_oe_n, // SDA enable
  input wire o_byte_event_flag, // Event
  input wire o_tx_bus_idle_flag, // Idle
  input wire o_received_ack_bit, // Ack
  input wire o_master_active_flag, // Active
  input wire o_bus_busy_flag, // Busy
  input wire o_data_phase // Data
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_EVENT_SCL: assert property (o_byte_event_flag [*2] |-> !o_scl_oe_n) else $error("scl free in wait");
  AST_IDLE_SCL: assert property (o_tx_bus_idle_flag [*2] |-> !o_scl_oe_n) else $error("scl free in idle");
  AST_CLEAR: assert property (o_byte_event_flag && i_event_clear_wr && i_master_select && !i_repeated_start_request
    |=> !o_byte_event_flag) else $error("event not cleared");
  AST_ABORT: assert property (o_byte_event_flag && (!i_master_select || i_repeated_start_request)
    |=> !o_byte_event_flag) else $error("event kept on abort");
  AST_IDLE_CLEAR: assert property (o_tx_bus_idle_flag && i_tx_data_wr |=> !o_tx_bus_idle_flag) else $error("idle kept");
  AST_IDLE_CAUSE: assert property ($rose(o_tx_bus_idle_flag) |-> i_dma_mode && !o_received_ack_bit)
    else $error("idle without cause");
  AST_START: assert property ($rose(o_master_active_flag) |-> !o_sda_oe_n && o_scl_oe_n) else $error("bad start");
  AST_SDA_STEADY: assert property (o_scl_oe_n && $past(o_bus_busy_flag) |-> $stable(o_sda_oe_n))
    else $error("sda moved while scl high");
  AST_DATA: assert property ($rose(o_data_phase) |-> !o_received_ack_bit && !o_byte_event_flag && !o_tx_bus_idle_flag)
    else $error("data phase without ack");
endmodule // i2c_addr_ack_chk
bind i2c_master_address_ack_handler i2c_addr_ack_chk i_chk (.*);

/* bench/i2c_master_address_ack_handler_test.sv */
// Self-checking bench for the address and acknowledge handler.
// Assumes the slave model and pulled-up open-drain bus lines.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module i2c_master_address_ack_handler_test;
  reg        i_core_clk = 0, i_resetn = 0, ms = 0, rs = 0, clr = 0, twr = 0, wps = 0;
  reg        rsv = 0, dma = 0, txf = 0, rxf = 0, rxd = 0, emp = 0, nack = 0;
  reg  [7:0] transmit_data_reg = 8'h00;
  wire       scl_oe_n, sda_oe_n, sda_low, ev, tx_bus_idle_flag, received_ack_bit, act, busy, dph, scl_drv, sda_drv;
  wire [7:0] seen;
  wire       scl = scl_oe_n;
  wire       sda = sda_oe_n & ~sda_low;
  integer    bad_count = 0, check_count = 0, cyc = 0, k;
  always #2 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) stop_test(1);
  end
  i2c_master_address_ack_handler #(.HALF_PERIOD(16'h0004)) i_dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_enable(1'b1), .i_master_select(ms),
    .i_repeated_start_request(rs), .i_dma_mode(dma), .i_tx_fifo_en(txf), .i_rx_fifo_en(rxf),
    .i_rx_fifo_has_data(rxd), .i_reserved_addr(rsv), .i_wait_point_select(wps), .i_tx_holding_empty(emp),
    .i_transmit_data_reg(transmit_data_reg), .i_event_clear_wr(clr), .i_tx_data_wr(twr), .i_scl_in(scl), .i_sda_in(sda),
    .o_scl_out(scl_drv), .o_scl_oe_n(scl_oe_n), .o_sda_out(sda_drv), .o_sda_oe_n(sda_oe_n), .o_byte_event_flag(ev),
    .o_tx_bus_idle_flag(tx_bus_idle_flag), .o_received_ack_bit(received_ack_bit), .o_master_active_flag(act),
    .o_bus_busy_flag(busy), .o_data_phase(dph));
  i2c_slave_model i_slave (.scl(scl), .sda(sda), .nack(nack), .sda_low(sda_low), .addr_seen(seen));
  task stop_test(input integer extra); begin
    bad_count = bad_count + extra;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task settle; begin
    k = 0;
    while (ev !== 1'b1 && tx_bus_idle_flag !== 1'b1 && dph !== 1'b1 && k < 400) begin
      @(posedge i_core_clk);
      #1 k = k + 1;
    end
  end endtask
  task pulse(input [2:0] w); begin
    @(posedge i_core_clk) {rs, twr, clr} <= w;
    @(posedge i_core_clk) {rs, twr, clr} <= 3'h0;
    #1;
  end endtask
  // Fresh reset, config {rsv,dma,txf,rxf,rxd,emp,nack}, then request
  task go(input [7:0] a, input [6:0] c); begin
    @(posedge i_core_clk) i_resetn <= 1'b0;
    ms <= 1'b0;
    {rsv, dma, txf, rxf, rxd, emp, nack} <= c;
    transmit_data_reg <= a;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk) ms <= 1'b1;
    settle;
    `CHK("active", 1'b1, act)
    `CHK("busy", 1'b1, busy)
  end endtask
  task t_empty; begin
    go(8'ha4, 7'h02);
    `CHK("event", 1'b1, ev)
    `CHK("addr", 8'ha4, seen)
    `CHK("received_ack_bit", 1'b0, received_ack_bit)
    `CHK("scl", 1'b0, scl)
    `CHK("levels", 2'h0, {scl_drv, sda_drv})
    pulse(3'h1);
    `CHK("clear", 1'b0, ev)
  end endtask
  task t_full; begin
    go(8'ha5, 7'h00);
    `CHK("data", 1'b1, dph)
    `CHK("event", 1'b0, ev)
  end endtask
  task t_dma; begin
    go(8'h3c, 7'h22);
    `CHK("idle", 1'b1, tx_bus_idle_flag)
    `CHK("event", 1'b0, ev)
    pulse(3'h2);
    `CHK("idle", 1'b0, tx_bus_idle_flag)
    go(8'h3c, 7'h20);
    `CHK("data", 1'b1, dph)
    `CHK("idle", 1'b0, tx_bus_idle_flag)
  end endtask
  task t_fifo; begin
    go(8'ha4, 7'h1a);
    `CHK("data", 1'b1, dph)
    go(8'ha5, 7'h1c);
    `CHK("data", 1'b1, dph)
    `CHK("event", 1'b0, ev)
    go(8'ha4, 7'h2c);
    `CHK("event", 1'b1, ev)
  end endtask
  task t_nack; begin
    go(8'h5a, 7'h13);
    `CHK("event", 1'b1, ev)
    `CHK("received_ack_bit", 1'b1, received_ack_bit)
    pulse(3'h4);
    `CHK("abort", 1'b0, ev)
    go(8'h5a, 7'h23);
    `CHK("event", 1'b1, ev)
    `CHK("idle", 1'b0, tx_bus_idle_flag)
    @(posedge i_core_clk) ms <= 1'b0;
    @(posedge i_core_clk);
    #1 `CHK("stop", 1'b0, ev)
  end endtask
  task t_rsv; begin
    @(posedge i_core_clk) wps <= 1'b1;
    go(8'h00, 7'h40);
    `CHK("event", 1'b1, ev)
    `CHK("bits", 32'h0000_0008, i_slave.n)
    pulse(3'h1);
    settle;
    `CHK("data", 1'b1, dph)
    `CHK("received_ack_bit", 1'b0, received_ack_bit)
  end endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    t_empty;
    t_full;
    t_dma;
    t_fifo;
    t_nack;
    t_rsv;
    stop_test(0);
  end
endmodule // i2c_master_address_ack_handler_test
